/* File: host_irq_regs.svh */
// Register offsets, field positions, reset values and timing for the interrupt controller
`ifndef HOST_IRQ_REGS_SVH
`define HOST_IRQ_REGS_SVH
`define IRQ_CONFIGURATION_OFS   8'h54
`define INTERRUPT_STATUS_OFS    8'h58
`define INTERRUPT_MASK_OFS      8'h5c
`define IRQ_CONFIGURATION_RST   32'h0000_0000
`define INTERRUPT_STATUS_RST    32'h0000_0000
`define INTERRUPT_MASK_RST      32'h0000_0000
`define HOLDOFF_MSB             31
`define HOLDOFF_LSB             24
`define HOLDOFF_RESTART_BIT     14
`define HOLDOFF_ACTIVE_BIT      13
`define MASTER_LINE_BIT         12
`define PIN_ENABLE_BIT          8
`define PIN_POLARITY_BIT        4
`define PIN_DRIVER_BIT          0
`define SOFTWARE_EVENT_BIT      31
`define TX_HALTED_BIT           25
`define RX_HALTED_BIT           24
`define DROP_MIDPOINT_BIT       23
`define PM_EVENT_BIT            17
`define CONFIG_WRITE_MASK       32'hff00_0111
`define KEPT_ON_SOFT_RESET_MASK 32'h0000_0011
`define STATUS_W1C_MASK         32'h83bb_efff
`define STATUS_LIVE_MASK        32'h0004_0000
`define STATUS_READ_CLEAR_MASK  32'h0000_0000
`define MASK_WRITE_MASK         32'h83bf_efff
`define PM_EVENT_MASK           32'h0002_0000
`define HOLDOFF_UNIT_NS         10000
`define CLK_PERIOD_NS           10
`define HOLDOFF_UNIT_CYCLES     (`HOLDOFF_UNIT_NS / `CLK_PERIOD_NS)
`endif

/* File: host_irq_pkg.sv */
// Types shared by the interrupt controller modules
package host_irq_pkg;
  typedef enum logic [0:0] {HOLDOFF_IDLE, HOLDOFF_RUN} holdoff_state_e;
  typedef logic [31:0] word_t;
endpackage : host_irq_pkg

/* File: holdoff_if.sv */
// Link between the register block and the hold-off timer
`timescale 1ns/1ps
interface holdoff_if;
  logic [7:0] interval;
  logic       start;
  logic       restart;
  logic       active;
  modport ctrl  (output interval, output start, output restart, input active);
  modport timer (input interval, input start, input restart, output active);
endinterface : holdoff_if

/* File: pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned          WIDTH       = 1,
  parameter logic [WIDTH-1:0]     RESET_VALUE = '0
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // First stage feeds only the second
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta <= RESET_VALUE;
      q_o  <= RESET_VALUE;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule : pin_sync

/* File: holdoff_timer.sv */
// Deassertion hold-off interval timer, counted in 10 us units
`timescale 1ns/1ps
`include "host_irq_regs.svh"
module holdoff_timer
  import host_irq_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `HOLDOFF_UNIT_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  holdoff_if.timer  hb
);
  localparam int unsigned PW = $clog2(UNIT_CYCLES + 1);
  localparam logic [PW-1:0] UNIT_LAST = PW'(UNIT_CYCLES - 1);

  holdoff_state_e state;
  holdoff_state_e next_state;
  logic [PW-1:0]  prescale;
  logic [PW-1:0]  next_prescale;
  logic [7:0]     units;
  logic [7:0]     next_units;
  logic [7:0]     length;
  logic [7:0]     next_length;

  // Interval length latched at start so a nonzero rewrite only affects later intervals
  always_comb begin
    next_state    = state;
    next_prescale = prescale;
    next_units    = units;
    next_length   = length;
    case (state)
      HOLDOFF_IDLE: begin
        if ((hb.start || hb.restart) && hb.interval != 8'h00) begin
          next_state    = HOLDOFF_RUN;
          next_length   = hb.interval;
          next_prescale = '0;
          next_units    = 8'h00;
        end
      end
      HOLDOFF_RUN: begin
        if (prescale == UNIT_LAST) begin
          next_prescale = '0;
          next_units    = units + 8'h01;
          if (units + 8'h01 == length) begin
            next_state = HOLDOFF_IDLE;
          end
        end else begin
          next_prescale = prescale + PW'(1);
        end
        if (hb.restart) begin
          next_prescale = '0;
          next_units    = 8'h00;
          next_length   = hb.interval;
          next_state    = HOLDOFF_RUN;
        end
      end
      default: next_state = HOLDOFF_IDLE;
    endcase
    // Zero field stops the interval at once
    if (hb.interval == 8'h00) begin
      next_state    = HOLDOFF_IDLE;
      next_prescale = '0;
      next_units    = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state    <= HOLDOFF_IDLE;
      prescale <= '0;
      units    <= 8'h00;
      length   <= 8'h00;
    end else begin
      state    <= next_state;
      prescale <= next_prescale;
      units    <= next_units;
      length   <= next_length;
    end
  end

  assign hb.active = (state == HOLDOFF_RUN);

  zero_stops_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hb.interval == 8'h00 |=> !hb.active) else $error("hold-off still running after zero field");
  restart_fresh_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hb.restart && hb.interval != 8'h00 |=> hb.active && units == 8'h00 && prescale == '0)
    else $error("restart did not begin a fresh interval");
  holdoff_run_c: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $fell(hb.active));
endmodule : holdoff_timer

/* File: host_irq_controller.sv */
// Host interrupt controller: status, mask, configuration and request pin
`timescale 1ns/1ps
`include "host_irq_regs.svh"
module host_irq_controller
  import host_irq_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `HOLDOFF_UNIT_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        soft_reset_i,
  input  wire logic        bus_cs_n_i,
  input  wire logic        bus_rd_n_i,
  input  wire logic        bus_wr_n_i,
  input  wire logic [7:1]  bus_addr_i,
  input  wire logic [15:0] bus_data_i,
  output logic      [15:0] bus_data_o,
  output logic             bus_data_oe_o,
  output logic             irq_o,
  output logic             irq_oe_o,
  input  wire logic        tx_stop_request_i,
  input  wire logic        tx_halted_i,
  input  wire logic        receiver_halted_i,
  input  wire logic [31:0] drop_count_i,
  input  wire logic        phy_irq_i,
  input  wire logic [31:0] source_events_i
);
  localparam logic [7:0]  CFG_OFS  = `IRQ_CONFIGURATION_OFS;
  localparam logic [7:0]  STS_OFS  = `INTERRUPT_STATUS_OFS;
  localparam logic [7:0]  MASK_OFS = `INTERRUPT_MASK_OFS;
  localparam logic [25:0] SYNC_RST = {3'b111, 23'h000000};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus strobes
  logic [25:0] pin_q;
  logic        s_cs_n;
  logic        s_rd_n;
  logic        s_wr_n;
  logic [7:1]  s_addr;
  logic [15:0] s_data;

  pin_sync #(.WIDTH(26), .RESET_VALUE(SYNC_RST)) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({bus_cs_n_i, bus_rd_n_i, bus_wr_n_i, bus_addr_i, bus_data_i}),
    .q_o       (pin_q)
  );
  assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_data} = pin_q;

  logic        rd_act;
  logic        wr_act;
  logic        rd_prev;
  logic        wr_prev;
  logic [7:1]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic        next_rd_prev;
  logic        next_wr_prev;
  logic [7:1]  next_wr_addr_q;
  logic [15:0] next_wr_data_q;
  logic [15:0] next_bus_data_o;
  logic        next_bus_data_oe_o;
  logic        rd_start;
  logic        wr_commit;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;
  word_t       rd_word;

  assign rd_act    = !s_cs_n && !s_rd_n;
  assign wr_act    = !s_cs_n && !s_wr_n;
  assign rd_start  = rd_act && !rd_prev;
  assign wr_commit = !wr_act && wr_prev;   // Commit on strobe release, data captured while held
  assign rd_byte   = {s_addr, 1'b0};
  assign wr_byte   = {wr_addr_q, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  word_t cfg;
  word_t sts;
  word_t mask;
  logic  sw_prev;
  logic  txh_prev;
  logic  rxh_prev;
  logic  drop_msb_prev;
  logic  pin_q_assert;
  word_t next_cfg;
  word_t next_sts;
  word_t next_mask;
  logic  next_sw_prev;
  logic  next_txh_prev;
  logic  next_rxh_prev;
  logic  next_drop_msb_prev;
  logic  next_pin_q_assert;
  logic  next_irq_o;
  logic  next_irq_oe_o;

  holdoff_if hb ();

  holdoff_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_holdoff_timer (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .hb        (hb.timer)
  );

  word_t sts_view;
  word_t set_vec;
  word_t wr_word;
  word_t half_mask;
  word_t w1c_clear;
  word_t rc_clear;
  logic  is_cfg_wr;
  logic  is_sts_wr;
  logic  is_mask_wr;
  logic  set_sw;
  logic  set_tx;
  logic  set_rx;
  logic  set_drop;
  logic  line;
  logic  held_part;
  logic  pm_part;
  logic  pin_assert;

  // Bit 18 follows its source live; the other STATUS_W1C_MASK bits are sticky, the rest read zero
  assign sts_view = (sts & ~`STATUS_LIVE_MASK) | ({32{phy_irq_i}} & `STATUS_LIVE_MASK);
  assign line      = |(sts_view & mask);
  assign pm_part   = |(sts_view & mask & `PM_EVENT_MASK);
  assign held_part = |(sts_view & mask & ~`PM_EVENT_MASK);
  assign pin_assert = cfg[`PIN_ENABLE_BIT] && ((held_part && !hb.active) || pm_part);

  // Event edges and source event levels into the status bits
  assign set_sw   = mask[`SOFTWARE_EVENT_BIT] && !sw_prev;
  assign set_tx   = tx_stop_request_i && tx_halted_i && !txh_prev;
  assign set_rx   = receiver_halted_i && !rxh_prev;
  assign set_drop = drop_count_i[31] && !drop_msb_prev && (drop_count_i[30:0] == 31'h0);
  assign set_vec  = (source_events_i & `STATUS_W1C_MASK & 32'h7c7f_ffff)
                  | ({31'h0, set_sw} << `SOFTWARE_EVENT_BIT)
                  | ({31'h0, set_tx} << `TX_HALTED_BIT)
                  | ({31'h0, set_rx} << `RX_HALTED_BIT)
                  | ({31'h0, set_drop} << `DROP_MIDPOINT_BIT);

  // Write decode per 16-bit half
  assign half_mask  = wr_addr_q[1] ? 32'hffff_0000 : 32'h0000_ffff;
  assign wr_word    = wr_addr_q[1] ? {wr_data_q, 16'h0000} : {16'h0000, wr_data_q};
  assign is_cfg_wr  = wr_commit && (wr_byte[7:2] == CFG_OFS[7:2]);
  assign is_sts_wr  = wr_commit && (wr_byte[7:2] == STS_OFS[7:2]);
  assign is_mask_wr = wr_commit && (wr_byte[7:2] == MASK_OFS[7:2]);
  assign w1c_clear  = is_sts_wr ? (wr_word & half_mask & `STATUS_W1C_MASK) : 32'h0;
  assign rc_clear   = (rd_start && rd_byte[7:2] == STS_OFS[7:2]) ? `STATUS_READ_CLEAR_MASK : 32'h0;

  assign hb.interval = cfg[`HOLDOFF_MSB:`HOLDOFF_LSB];
  assign hb.restart  = is_cfg_wr && !wr_addr_q[1] && wr_data_q[`HOLDOFF_RESTART_BIT];
  assign hb.start    = pin_q_assert && !pin_assert;

  // Next register values
  always_comb begin
    next_cfg  = cfg;
    next_mask = mask;
    if (is_cfg_wr) begin
      next_cfg = (cfg & ~(`CONFIG_WRITE_MASK & half_mask)) | (wr_word & `CONFIG_WRITE_MASK & half_mask);
    end
    if (is_mask_wr) begin
      next_mask = (mask & ~(`MASK_WRITE_MASK & half_mask)) | (wr_word & `MASK_WRITE_MASK & half_mask);
    end
    // Set wins over any clear in the same cycle
    next_sts = ((sts & ~w1c_clear & ~rc_clear) | set_vec) & `STATUS_W1C_MASK;
    if (soft_reset_i) begin
      next_cfg  = (`IRQ_CONFIGURATION_RST & ~`KEPT_ON_SOFT_RESET_MASK)
                | (cfg & `KEPT_ON_SOFT_RESET_MASK);
      next_mask = `INTERRUPT_MASK_RST;
      next_sts  = `INTERRUPT_STATUS_RST | set_vec;
    end
    next_sw_prev       = mask[`SOFTWARE_EVENT_BIT];
    next_txh_prev      = tx_stop_request_i && tx_halted_i;
    next_rxh_prev      = receiver_halted_i;
    next_drop_msb_prev = drop_count_i[31];
    next_pin_q_assert  = pin_assert;
    if (!cfg[`PIN_DRIVER_BIT]) begin
      next_irq_o    = 1'b0;
      next_irq_oe_o = pin_assert;
    end else begin
      next_irq_o    = cfg[`PIN_POLARITY_BIT] ? pin_assert : !pin_assert;
      next_irq_oe_o = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg           <= `IRQ_CONFIGURATION_RST;
      sts           <= `INTERRUPT_STATUS_RST;
      mask          <= `INTERRUPT_MASK_RST;
      sw_prev       <= 1'b0;
      txh_prev      <= 1'b0;
      rxh_prev      <= 1'b0;
      drop_msb_prev <= 1'b0;
      pin_q_assert  <= 1'b0;
      irq_o         <= 1'b0;
      irq_oe_o      <= 1'b0;
    end else begin
      cfg           <= next_cfg;
      sts           <= next_sts;
      mask          <= next_mask;
      sw_prev       <= next_sw_prev;
      txh_prev      <= next_txh_prev;
      rxh_prev      <= next_rxh_prev;
      drop_msb_prev <= next_drop_msb_prev;
      pin_q_assert  <= next_pin_q_assert;
      irq_o         <= next_irq_o;
      irq_oe_o      <= next_irq_oe_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0;
    if (rd_byte[7:2] == CFG_OFS[7:2]) begin
      rd_word = (cfg & `CONFIG_WRITE_MASK)
              | ({31'h0, hb.active} << `HOLDOFF_ACTIVE_BIT)
              | ({31'h0, line} << `MASTER_LINE_BIT);
    end else if (rd_byte[7:2] == STS_OFS[7:2]) begin
      rd_word = sts_view;
    end else if (rd_byte[7:2] == MASK_OFS[7:2]) begin
      rd_word = mask;
    end
  end

  // Bus capture and answer
  always_comb begin
    next_rd_prev       = rd_act;
    next_wr_prev       = wr_act;
    next_wr_addr_q     = wr_act ? s_addr : wr_addr_q;
    next_wr_data_q     = wr_act ? s_data : wr_data_q;
    next_bus_data_oe_o = rd_act;
    next_bus_data_o    = bus_data_o;
    if (rd_start) begin
      next_bus_data_o = s_addr[1] ? rd_word[31:16] : rd_word[15:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_prev       <= 1'b0;
      wr_prev       <= 1'b0;
      wr_addr_q     <= 7'h00;
      wr_data_q     <= 16'h0000;
      bus_data_o    <= 16'h0000;
      bus_data_oe_o <= 1'b0;
    end else begin
      rd_prev       <= next_rd_prev;
      wr_prev       <= next_wr_prev;
      wr_addr_q     <= next_wr_addr_q;
      wr_data_q     <= next_wr_data_q;
      bus_data_o    <= next_bus_data_o;
      bus_data_oe_o <= next_bus_data_oe_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  w1c_clear_a: assert property (is_sts_wr && wr_addr_q[1] && wr_data_q[15] && !set_sw |=> !sts[31])
    else $error("write one did not clear status bit");
  ro_bits_a: assert property ((cfg & ~`CONFIG_WRITE_MASK) == 32'h0)
    else $error("read-only configuration bits changed");
  soft_keep_a: assert property (soft_reset_i |=> cfg[4] == $past(cfg[4]) && cfg[0] == $past(cfg[0])
    && cfg[31:24] == 8'h00 && mask == 32'h0) else $error("soft reset handled wrong");
  pm_through_a: assert property (cfg[8] && pm_part && hb.active |-> pin_assert)
    else $error("power management event held off");
  holdoff_block_a: assert property (hb.active && !pm_part |-> !pin_assert)
    else $error("interrupt reached pin during hold-off");
  line_bit_a: assert property (rd_start && rd_byte[7:2] == CFG_OFS[7:2] && !s_addr[1] |=>
    bus_data_o[12] == $past(line)) else $error("master line bit wrong");
  pin_off_a: assert property (!cfg[8] |=> !pin_q_assert && irq_oe_o == $past(cfg[0])
    && irq_o == ($past(cfg[0]) && !$past(cfg[4]))) else $error("pin not deasserted while disabled");
  open_drain_a: assert property (!cfg[0] && !$past(cfg[0]) |-> irq_o == 1'b0 && irq_oe_o == $past(pin_assert))
    else $error("open-drain drive wrong");
  polarity_a: assert property (cfg[0] && $past(cfg[0]) && $stable(cfg[4]) |-> irq_o == (cfg[4] ~^ $past(pin_assert)))
    else $error("push-pull polarity wrong");
  sw_event_a: assert property (set_sw |=> sts[31])
    else $error("software event not latched");
  drop_mid_a: assert property (set_drop |=> sts[23] ##1 sts[23] || $past(is_sts_wr) || $past(soft_reset_i))
    else $error("drop midpoint not latched");

  pin_assert_c: cover property (pin_assert ##1 !pin_assert ##1 hb.active);
  pm_pin_c: cover property (pm_part && hb.active && pin_assert);
  clear_c: cover property (is_sts_wr && |w1c_clear);
endmodule : host_irq_controller

/* File: host_bus_model.sv */
// Host processor model on the 16-bit SRAM-like register bus
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        sys_clk_i,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [7:1]       addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rdata_oe_i
);
  int unsigned hold = 6; // Strobe length; raise it to act as a slow host
  // Idle bus at time zero
  initial begin
    {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
    addr_o = 7'h00;
    wdata_o = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One strobe; all held until read data is taken, then a long gap
  task automatic strobe(input logic [7:1] a, input logic wr, input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk_i);
    addr_o  <= a;
    wdata_o <= wr ? d : ~wdata_o; // Read cycles leave the data lines moving
    cs_n_o  <= 1'b0;
    rd_n_o  <= wr;
    wr_n_o  <= !wr;
    repeat (hold) @(posedge sys_clk_i);
    q = rdata_oe_i ? rdata_i : ~rdata_i; // Undriven bus reads as garbage
    {cs_n_o, rd_n_o, wr_n_o} <= 3'h7;
    wdata_o <= ~wdata_o; // Released lines never keep the last value
    repeat (4) @(posedge sys_clk_i);
  endtask : strobe
  // Register is low half then high half
  task automatic write32(input logic [7:0] ofs, input logic [31:0] v);
    logic [15:0] q;
    strobe({ofs[7:2], 1'b0}, 1'b1, v[15:0], q);
    strobe({ofs[7:2], 1'b1}, 1'b1, v[31:16], q);
  endtask : write32
  task automatic read32(input logic [7:0] ofs, output logic [31:0] v);
    strobe({ofs[7:2], 1'b0}, 1'b0, 16'h0000, v[15:0]);
    strobe({ofs[7:2], 1'b1}, 1'b0, 16'h0000, v[31:16]);
  endtask : read32
endmodule : host_bus_model

/* File: tb_top.sv */
// Self-checking bench for the host interrupt controller
`timescale 1ns/1ps
`include "host_irq_regs.svh"
module tb_top;
  import host_irq_pkg::*;
  localparam int unsigned UNIT = 4; // Short hold-off unit keeps the run brief
  logic        sys_clk_i, sys_rst_i, soft_reset_i, tx_stop_request_i, tx_halted_i, receiver_halted_i, phy_irq_i;
  logic        cs_n, rd_n, wr_n, irq_o, irq_oe_o, exp_hold, rd_oe;
  logic [7:1]  addr;
  logic [15:0] wdata, rdata;
  word_t       drop_count_i, source_events_i, exp_cfg, exp_sts, exp_msk, got, lfsr;
  int          fails, cmp_count;

  host_bus_model i_host (.sys_clk_i(sys_clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rdata_oe_i(rd_oe));
  host_irq_controller #(.UNIT_CYCLES(UNIT)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .soft_reset_i(soft_reset_i), .bus_cs_n_i(cs_n), .bus_rd_n_i(rd_n), .bus_wr_n_i(wr_n),
    .bus_addr_i(addr), .bus_data_i(wdata), .bus_data_o(rdata), .bus_data_oe_o(rd_oe), .irq_o(irq_o),
    .irq_oe_o(irq_oe_o), .tx_stop_request_i(tx_stop_request_i), .tx_halted_i(tx_halted_i),
    .receiver_halted_i(receiver_halted_i), .drop_count_i(drop_count_i), .phy_irq_i(phy_irq_i),
    .source_events_i(source_events_i));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs about 1600 cycles
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////////
  // Model helpers
  function automatic word_t lfsr_step(input word_t s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  function automatic logic enabled_line();
    return |(exp_sts & exp_msk);
  endfunction : enabled_line
  function automatic word_t cfg_view();
    return exp_cfg | {18'h0, exp_hold, enabled_line(), 12'h0};
  endfunction : cfg_view
  task automatic check(input word_t seen, input word_t want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic reg_check(input logic [7:0] ofs, input word_t want);
    i_host.read32(ofs, got);
    check(got, want);
  endtask : reg_check
  // Power management request bypasses the hold-off
  task automatic pin_check();
    logic       req;
    logic [1:0] want;
    repeat (2) @(posedge sys_clk_i);
    #1;
    req = exp_cfg[8] & (enabled_line() & !exp_hold | exp_sts[17] & exp_msk[17]);
    want = exp_cfg[0] ? {exp_cfg[4] == req, 1'b1} : {1'b0, req};
    check({30'h0, irq_o, irq_oe_o}, {30'h0, want});
    @(posedge sys_clk_i);
  endtask : pin_check
  task automatic pulse(input word_t ev);
    source_events_i <= ev;
    @(posedge sys_clk_i);
    source_events_i <= '0;
    exp_sts |= ev & 32'h003b_efff;
    repeat (3) @(posedge sys_clk_i);
  endtask : pulse
  task automatic set_cfg(input word_t v);
    i_host.write32(`IRQ_CONFIGURATION_OFS, v);
    exp_cfg = v & `CONFIG_WRITE_MASK;
  endtask : set_cfg
  task automatic clear_sts(input word_t v);
    i_host.write32(`INTERRUPT_STATUS_OFS, v);
    exp_sts &= ~(v & `STATUS_W1C_MASK);
  endtask : clear_sts
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {sys_rst_i, soft_reset_i, tx_stop_request_i, tx_halted_i, receiver_halted_i, phy_irq_i} = 6'h20;
    {drop_count_i, source_events_i, exp_cfg, exp_sts, exp_msk} = '0;
    {exp_hold, fails, cmp_count} = '0;
    lfsr = 32'd58612;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // Defaults, plus the unmapped slot after the mask register
    for (int o = 'h54; o <= 'h60; o += 4) reg_check(o[7:0], '0);
    // Random masks; the top bit toggles to raise the software event
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_step(lfsr);
      lfsr[31] = i[0];
      if (lfsr[31] & !exp_msk[31]) exp_sts[31] = 1'b1;
      exp_msk = lfsr & `MASK_WRITE_MASK;
      i_host.write32(`INTERRUPT_MASK_OFS, exp_msk);
      reg_check(`INTERRUPT_MASK_OFS, exp_msk);
      reg_check(`INTERRUPT_STATUS_OFS, exp_sts);
    end
    // Random bursts, then clears that also hit the live read-only bit
    phy_irq_i <= 1'b1;
    exp_sts[18] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_step(lfsr);
      pulse(lfsr);
      reg_check(`INTERRUPT_STATUS_OFS, exp_sts);
      lfsr = lfsr_step(lfsr);
      clear_sts(lfsr & `STATUS_W1C_MASK | 32'h0004_0000);
      reg_check(`INTERRUPT_STATUS_OFS, exp_sts);
    end
    // Halt conditions; transmit counts only once stop is requested too
    tx_halted_i <= 1'b1;
    receiver_halted_i <= 1'b1;
    drop_count_i <= 32'h7fff_ffff;
    @(posedge sys_clk_i);
    tx_stop_request_i <= 1'b1;
    drop_count_i <= 32'h8000_0000;
    exp_sts |= 32'h0380_0000;
    reg_check(`INTERRUPT_STATUS_OFS, exp_sts);
    phy_irq_i <= 1'b0;
    exp_sts[18] = 1'b0;
    clear_sts(`STATUS_W1C_MASK);
    reg_check(`INTERRUPT_STATUS_OFS, exp_sts);
    exp_msk = 32'h0002_0008;
    i_host.write32(`INTERRUPT_MASK_OFS, exp_msk);
    // Every enable, polarity and driver combination
    for (int i = 0; i < 8; i++) begin
      set_cfg({23'h0, i[2], 3'h0, i[1], 3'h0, i[0]});
      pulse(32'h8);
      pin_check();
      reg_check(`IRQ_CONFIGURATION_OFS, cfg_view());
      clear_sts(32'h8);
      pin_check();
    end
    // Hold-off blocks requests but never the power management event
    set_cfg(32'h4000_0111);
    pulse(32'h8);
    clear_sts(32'h8);
    exp_hold = 1'b1;
    pulse(32'h8);
    pin_check();
    reg_check(`IRQ_CONFIGURATION_OFS, cfg_view());
    pulse(32'h0002_0000);
    pin_check();
    clear_sts(32'h0002_0000);
    pin_check();
    set_cfg(32'h0000_0111);
    exp_hold = 1'b0;
    pin_check();
    // Shorter interval runs out; restart opens a fresh one
    set_cfg(32'h0800_0111);
    clear_sts(32'h8);
    exp_hold = 1'b1;
    reg_check(`IRQ_CONFIGURATION_OFS, cfg_view());
    exp_hold = 1'b0;
    repeat (40) @(posedge sys_clk_i);
    reg_check(`IRQ_CONFIGURATION_OFS, cfg_view());
    set_cfg(32'h0800_4111);
    exp_hold = 1'b1;
    reg_check(`IRQ_CONFIGURATION_OFS, cfg_view());
    // Soft reset keeps only polarity and driver type
    pulse(32'h8);
    soft_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    soft_reset_i <= 1'b0;
    exp_cfg &= `KEPT_ON_SOFT_RESET_MASK;
    {exp_sts, exp_msk, exp_hold} = '0;
    reg_check(`IRQ_CONFIGURATION_OFS, exp_cfg);
    reg_check(`INTERRUPT_STATUS_OFS, exp_sts);
    reg_check(`INTERRUPT_MASK_OFS, exp_msk);
    final_report();
  end
endmodule : tb_top
